// ### tmc_pkg.sv
// Package for the 16-bit timer control slice: offsets, fields, modes, timing
package tmc_pkg;
    // Register byte offsets on the AHB-Lite bus (one aligned word each)
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_FORCE = 8'h08;
    localparam logic [7:0] OFF_CNT_L = 8'h0C;
    localparam logic [7:0] OFF_CNT_H = 8'h10;
    localparam logic [7:0] OFF_CMPA_L = 8'h14;
    localparam logic [7:0] OFF_CMPA_H = 8'h18;
    localparam logic [7:0] OFF_CMPB_L = 8'h1C;
    localparam logic [7:0] OFF_CMPB_H = 8'h20;
    localparam logic [7:0] OFF_CAP_L = 8'h24;
    localparam logic [7:0] OFF_CAP_H = 8'h28;
    localparam logic [7:0] OFF_FLAGS = 8'h2C;
    // Control A fields
    localparam int CA_ACT_A_LSB = 6;
    localparam int CA_ACT_B_LSB = 4;
    localparam int CA_WGM_LSB = 0;
    // Control B fields
    localparam int CB_FILT = 7;
    localparam int CB_EDGE = 6;
    localparam int CB_WGM_LSB = 3;
    localparam int CB_CS_LSB = 0;
    localparam logic [7:0] CB_WMASK = 8'hDF;
    // Force strobe bits
    localparam int FC_A = 7;
    localparam int FC_B = 6;
    // Flag bits
    localparam int FL_CAP = 5;
    localparam int FL_CMPB = 2;
    localparam int FL_CMPA = 1;
    localparam int FL_OVF = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    // Fixed TOP values
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] BOTTOM = 16'h0000;
    // Prescale divisors
    localparam int DIV_8 = 8;
    localparam int DIV_64 = 64;
    localparam int DIV_256 = 256;
    localparam int DIV_1024 = 1024;
    localparam int FILT_SAMPLES = 4;
    // Clock source codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_D1 = 3'h1;
    localparam logic [2:0] CS_D8 = 3'h2;
    localparam logic [2:0] CS_D64 = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Waveform mode codes
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_CTC_A = 4'h4;
    localparam logic [3:0] WM_FAST8 = 4'h5;
    localparam logic [3:0] WM_FAST9 = 4'h6;
    localparam logic [3:0] WM_FAST10 = 4'h7;
    localparam logic [3:0] WM_PFC_CAP = 4'h8;
    localparam logic [3:0] WM_PFC_A = 4'h9;
    localparam logic [3:0] WM_PC_CAP = 4'hA;
    localparam logic [3:0] WM_PC_A = 4'hB;
    localparam logic [3:0] WM_CTC_CAP = 4'hC;
    localparam logic [3:0] WM_RSVD = 4'hD;
    localparam logic [3:0] WM_FAST_CAP = 4'hE;
    localparam logic [3:0] WM_FAST_A = 4'hF;
    // Compare output actions, non-PWM
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ### tmc_timer.sv
// Top of the 16-bit timer control slice with its AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Mode is four bits: two low in control A, two high in control B.
// - Sixteen mode codes; fast, phase correct variants; code 13 reserved.
// - Normal TOP 0xFFFF; clear-on-match TOP compare A or capture; immediate.
// - Phase correct 8/9/10 bit fixed TOP; buffers load at TOP; overflow at BOTTOM.
// - Phase-frequency correct TOP capture or A; buffers and overflow at BOTTOM.
// - Noise filter changes capture input after four equal samples.
// - Edge select zero means falling edge, one means rising edge.
// - Capture event copies counter into capture register and sets capture flag.
// - Capture-as-TOP modes disconnect the capture pin.
// - Clock select: stop, divide by 1, 8, 64, 256, 1024.
// - Codes 6 and 7 count falling and rising edges of count pin.
// - Count pin edges count even when pin is an output.
// - Force strobes act only in non-PWM modes, per output action bits.
// - Forced strobe raises no flag and never clears the counter.
// - Force bits are strobes and read back zero.
// - Counter reads and writes through a shared high-byte latch, atomically.
// - Counter write blocks compare match on the following timer clock.
// - Compare registers continuously compared; match drives flag and output.
// - Compare writes pass the shared latch; both bytes update together.
// - Compare flag sets the timer clock after equality; force does not.
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic clk, // 40 MHz I/O clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic capture_input_pin, // Capture pin, asynchronous
    input wire logic external_count_pin, // Count pin, asynchronous
    output logic compare_out_a, // Waveform A
    output logic compare_out_b, // Waveform B
    output logic compare_out_a_en, // A drives its pin
    output logic compare_out_b_en, // B drives its pin
    output logic [3:0] flags // Capture, compare B, compare A, overflow
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] cnt;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [15:0] cmpa_buf;
        logic [15:0] cmpb_buf;
        logic [15:0] cap;
        logic [7:0] temp;
        logic cap_f;
        logic cmpa_f;
        logic cmpb_f;
        logic ovf_f;
        logic down;
        logic block;
        logic [9:0] pre;
        logic [1:0] cap_sync;
        logic [1:0] ext_sync;
        logic cap_last;
        logic ext_last;
        logic [2:0] filt_cnt;
        logic cap_filt;
        logic wf_a;
        logic wf_b;
        logic en_a;
        logic en_b;
        logic ph_write;
        logic ph_sel;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } tmc_state_s;

    tmc_state_s s;
    tmc_state_s next_s;

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
        input logic [15:0] c);
        unique case (m)
            WM_PC8, WM_FAST8: top_of = TOP_8;
            WM_PC9, WM_FAST9: top_of = TOP_9;
            WM_PC10, WM_FAST10: top_of = TOP_10;
            WM_CTC_A, WM_PFC_A, WM_PC_A, WM_FAST_A: top_of = a;
            WM_CTC_CAP, WM_PFC_CAP, WM_PC_CAP, WM_FAST_CAP: top_of = c;
            default: top_of = TOP_MAX;
        endcase
    endfunction

    function automatic logic is_nonpwm(input logic [3:0] m);
        is_nonpwm = (m == WM_NORMAL) || (m == WM_CTC_A) || (m == WM_CTC_CAP);
    endfunction

    function automatic logic apply_act(input logic [1:0] act, input logic cur);
        unique case (act)
            ACT_TOGGLE: apply_act = ~cur;
            ACT_CLEAR: apply_act = 1'b0;
            ACT_SET: apply_act = 1'b1;
            default: apply_act = cur;
        endcase
    endfunction

    logic [3:0] mode;
    logic [15:0] top;
    logic [2:0] cs;
    logic tick;
    logic wr_ph;
    logic [7:0] wb;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bot;
    logic cap_edge;
    logic cap_in;
    logic fast;
    logic dual;
    logic [1:0] act_a;
    logic [1:0] act_b;

    always_comb
    begin
        mode = {s.ctrl_b[CB_WGM_LSB +: 2], s.ctrl_a[CA_WGM_LSB +: 2]};
        top = top_of(mode, s.cmpa, s.cap);
        cs = s.ctrl_b[CB_CS_LSB +: 3];
        act_a = s.ctrl_a[CA_ACT_A_LSB +: 2];
        act_b = s.ctrl_a[CA_ACT_B_LSB +: 2];
        fast = (mode == WM_FAST8) || (mode == WM_FAST9) || (mode == WM_FAST10)
            || (mode == WM_FAST_CAP) || (mode == WM_FAST_A);
        dual = !is_nonpwm(mode) && !fast && (mode != WM_RSVD);
        wb = hwdata[7:0];
        wr_ph = s.ph_sel && s.ph_write;
        unique case (cs)
            CS_STOP: tick = 1'b0;
            CS_D1: tick = 1'b1;
            CS_D8: tick = (s.pre[2:0] == 3'(DIV_8 - 1));
            CS_D64: tick = (s.pre[5:0] == 6'(DIV_64 - 1));
            CS_D256: tick = (s.pre[7:0] == 8'(DIV_256 - 1));
            CS_D1024: tick = (s.pre == 10'(DIV_1024 - 1));
            CS_EXT_FALL: tick = s.ext_last && !s.ext_sync[1];
            CS_EXT_RISE: tick = !s.ext_last && s.ext_sync[1];
        endcase
        cap_in = s.ctrl_b[CB_FILT] ? s.cap_filt : s.cap_sync[1];
        cap_edge = s.ctrl_b[CB_EDGE] ? (cap_in && !s.cap_last)
            : (!cap_in && s.cap_last);
        at_top = (s.cnt == top);
        at_bot = (s.cnt == BOTTOM);
        match_a = tick && !s.block && (s.cnt == s.cmpa) && (mode != WM_RSVD);
        match_b = tick && !s.block && (s.cnt == s.cmpb) && (mode != WM_RSVD);

        next_s = s;
        next_s.pre = (cs == CS_STOP) ? 10'h000 : s.pre + 10'h001;
        next_s.cap_sync = {s.cap_sync[0], capture_input_pin};
        next_s.ext_sync = {s.ext_sync[0], external_count_pin};
        next_s.ext_last = s.ext_sync[1];
        next_s.cap_last = cap_in;
        // Filter: four equal samples that differ from the output flip it
        if (s.cap_sync[1] == s.cap_filt)
            next_s.filt_cnt = 3'h0;
        else if (s.filt_cnt == 3'(FILT_SAMPLES - 1))
        begin
            next_s.filt_cnt = 3'h0;
            next_s.cap_filt = s.cap_sync[1];
        end
        else
            next_s.filt_cnt = s.filt_cnt + 3'h1;

        // Flag clears go first so that a set in the same cycle wins
        if (wr_ph && s.ph_addr == OFF_FLAGS)
        begin
            if (wb[FL_CAP])
                next_s.cap_f = 1'b0;
            if (wb[FL_CMPA])
                next_s.cmpa_f = 1'b0;
            if (wb[FL_CMPB])
                next_s.cmpb_f = 1'b0;
            if (wb[FL_OVF])
                next_s.ovf_f = 1'b0;
        end
        if (tick)
        begin
            next_s.block = 1'b0;
            if (dual)
            begin
                if (at_top && !s.down)
                    next_s.down = 1'b1;
                else if (at_bot && s.down)
                    next_s.down = 1'b0;
                next_s.cnt = (s.down && !at_bot) || (at_top && !s.down)
                    ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
            end
            else if (mode == WM_RSVD || mode == WM_NORMAL)
                next_s.cnt = s.cnt + 16'h0001;
            else
                next_s.cnt = at_top ? BOTTOM : s.cnt + 16'h0001;
            // Overflow point per mode
            if (is_nonpwm(mode) || mode == WM_RSVD)
            begin
                if (s.cnt == TOP_MAX)
                    next_s.ovf_f = 1'b1;
            end
            else if (fast)
            begin
                if (at_top)
                    next_s.ovf_f = 1'b1;
            end
            else if (at_bot && s.down)
                next_s.ovf_f = 1'b1;
            // Buffered compare update point
            if ((fast && at_top) || (dual && at_top && !s.down
                && mode != WM_PFC_CAP && mode != WM_PFC_A))
            begin
                next_s.cmpa = s.cmpa_buf;
                next_s.cmpb = s.cmpb_buf;
            end
            if ((mode == WM_PFC_CAP || mode == WM_PFC_A) && at_bot)
            begin
                next_s.cmpa = s.cmpa_buf;
                next_s.cmpb = s.cmpb_buf;
            end
            if ((mode == WM_CTC_CAP || mode == WM_FAST_CAP || mode == WM_PFC_CAP
                || mode == WM_PC_CAP) && at_top)
                next_s.cap_f = 1'b1;
        end
        if (match_a)
            next_s.cmpa_f = 1'b1;
        if (match_b)
            next_s.cmpb_f = 1'b1;
        // Waveform: non-PWM actions, fast set/clear at TOP, dual by direction
        if (match_a)
            next_s.wf_a = dual && act_a[1] ? act_a[0] ^ s.down
                : apply_act(act_a, s.wf_a);
        else if (fast && tick && at_top && act_a[1])
            next_s.wf_a = ~act_a[0];
        if (match_b)
            next_s.wf_b = dual && act_b[1] ? act_b[0] ^ s.down
                : apply_act(act_b, s.wf_b);
        else if (fast && tick && at_top && act_b[1])
            next_s.wf_b = ~act_b[0];
        next_s.en_a = (act_a != ACT_OFF) && (mode != WM_RSVD);
        next_s.en_b = (act_b[1] || (is_nonpwm(mode) && act_b != ACT_OFF)) && (mode != WM_RSVD);
        // Capture, disconnected when capture register is TOP
        if (cap_edge && top_of(mode, 16'h0000, 16'hFFFF) != TOP_MAX
            || cap_edge && mode == WM_NORMAL || cap_edge && mode == WM_RSVD
            || cap_edge && (top_of(mode, 16'hFFFF, 16'h0000) == TOP_MAX)
            && !(mode == WM_CTC_CAP || mode == WM_PFC_CAP || mode == WM_PC_CAP
            || mode == WM_FAST_CAP))
        begin
            if (!(mode == WM_CTC_CAP || mode == WM_PFC_CAP || mode == WM_PC_CAP
                || mode == WM_FAST_CAP))
            begin
                next_s.cap = s.cnt;
                next_s.cap_f = 1'b1;
            end
        end

        // Bus data phase: register writes land here; flag clears were taken above
        next_s.ph_sel = hready && hsel && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
        next_s.ph_write = hwrite;
        next_s.ph_addr = haddr;
        if (wr_ph)
        begin
            unique case (s.ph_addr)
                OFF_CTRL_A: next_s.ctrl_a = wb & 8'hF3;
                OFF_CTRL_B: next_s.ctrl_b = wb & CB_WMASK;
                OFF_FORCE:
                begin
                    if (is_nonpwm(mode) && wb[FC_A])
                        next_s.wf_a = apply_act(act_a, s.wf_a);
                    if (is_nonpwm(mode) && wb[FC_B])
                        next_s.wf_b = apply_act(act_b, s.wf_b);
                end
                OFF_CNT_H, OFF_CMPA_H, OFF_CMPB_H: next_s.temp = wb;
                OFF_CNT_L:
                begin
                    next_s.cnt = {s.temp, wb};
                    next_s.block = 1'b1;
                end
                OFF_CMPA_L:
                begin
                    next_s.cmpa_buf = {s.temp, wb};
                    if (is_nonpwm(mode) || mode == WM_RSVD)
                        next_s.cmpa = {s.temp, wb};
                end
                OFF_CMPB_L:
                begin
                    next_s.cmpb_buf = {s.temp, wb};
                    if (is_nonpwm(mode) || mode == WM_RSVD)
                        next_s.cmpb = {s.temp, wb};
                end
                default: ;
            endcase
        end
        // Read data for the next data phase; counter or capture low byte read fills the latch
        next_s.rdata = RD_ZERO;
        if (next_s.ph_sel && !hwrite)
        begin
            unique case (haddr)
                OFF_CTRL_A: next_s.rdata = {24'h0, s.ctrl_a};
                OFF_CTRL_B: next_s.rdata = {24'h0, s.ctrl_b};
                OFF_FORCE: next_s.rdata = RD_ZERO;
                OFF_CNT_L:
                begin
                    next_s.rdata = {24'h0, s.cnt[7:0]};
                    next_s.temp = s.cnt[15:8];
                end
                OFF_CAP_L:
                begin
                    next_s.rdata = {24'h0, s.cap[7:0]};
                    next_s.temp = s.cap[15:8];
                end
                OFF_CNT_H, OFF_CAP_H: next_s.rdata = {24'h0, s.temp};
                OFF_CMPA_L: next_s.rdata = {24'h0, s.cmpa_buf[7:0]};
                OFF_CMPA_H: next_s.rdata = {24'h0, s.cmpa_buf[15:8]};
                OFF_CMPB_L: next_s.rdata = {24'h0, s.cmpb_buf[7:0]};
                OFF_CMPB_H: next_s.rdata = {24'h0, s.cmpb_buf[15:8]};
                OFF_FLAGS: next_s.rdata = {26'h0, s.cap_f, 2'h0, s.cmpb_f, s.cmpa_f, s.ovf_f};
                default: next_s.rdata = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= RD_ZERO;
            compare_out_a <= 1'b0;
            compare_out_b <= 1'b0;
            compare_out_a_en <= 1'b0;
            compare_out_b_en <= 1'b0;
            flags <= 4'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hrdata <= next_s.rdata;
            compare_out_a <= next_s.wf_a;
            compare_out_b <= next_s.wf_b;
            compare_out_a_en <= next_s.en_a;
            compare_out_b_en <= next_s.en_b;
            flags <= {next_s.cap_f, next_s.cmpb_f, next_s.cmpa_f, next_s.ovf_f};
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    cnt_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ph && s.ph_addr == OFF_CNT_L) |=> !match_a)
        else $error("match not blocked after counter write");
    force_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ph && s.ph_addr == OFF_FORCE && !match_a && !s.cmpa_f) |=> !s.cmpa_f)
        else $error("force strobe set a flag");
    match_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        match_a |=> s.cmpa_f)
        else $error("compare flag missed");
    cap_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cap_edge && mode == WM_NORMAL) |=> (s.cap == $past(s.cnt) && s.cap_f))
        else $error("capture not taken");
    cap_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == WM_CTC_CAP && !tick && !wr_ph) |=> $stable(s.cap))
        else $error("capture active while capture is TOP");
    stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cs == CS_STOP && !wr_ph && $past(cs) == CS_STOP) |=> $stable(s.cnt))
        else $error("counter moved while stopped");
    rsvd_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == WM_RSVD) |=> !compare_out_a_en)
        else $error("output driven in reserved mode");
    force_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.ph_sel && !s.ph_write && s.ph_addr == OFF_FORCE) |-> hrdata == RD_ZERO)
        else $error("force bits read nonzero");
    ctrl_res_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s.ctrl_b[5])
        else $error("reserved bit stored");
    cov_capture: cover property (@(posedge clk) disable iff (!rst_n) cap_edge && s.cap_f);
    cov_match: cover property (@(posedge clk) disable iff (!rst_n) match_a);
    cov_ovf: cover property (@(posedge clk) disable iff (!rst_n) dual && s.ovf_f);
endmodule

// ### tmc_pin_model.sv
// Pin-side partner model driving the capture and count pins
`timescale 1ns/1ps
module tmc_pin_model
(
    input wire logic clk, // Bus clock
    output logic capture_input_pin, // Capture pin level
    output logic external_count_pin // Count pin level
);
    initial
    begin
        capture_input_pin = 1'b0;
        external_count_pin = 1'b0;
    end
    // Wide pulses so the pin synchroniser never misses an edge
    task automatic count_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk) external_count_pin <= 1'b1;
            repeat (4) @(posedge clk);
            external_count_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic drive_capture(input logic lvl, input int hold);
        @(posedge clk) capture_input_pin <= lvl;
        repeat (hold) @(posedge clk);
    endtask
endmodule

// ### tmc_timer_test.sv
// Self-checking testbench for the timer control slice
`timescale 1ns/1ps
module tmc_timer_test;
    import tmc_pkg::*;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic cap_pin, cnt_pin, out_a, out_b, en_a, en_b;
    logic [3:0] flags;
    logic [15:0] v;
    int errors, samples_checked;
    int divs[5] = '{1, DIV_8, DIV_64, DIV_256, DIV_1024};
    logic [7:0] offs[12] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_FORCE, OFF_CNT_L, OFF_CNT_H,
        OFF_CMPA_L, OFF_CMPA_H, OFF_CMPB_L, OFF_CMPB_H, OFF_CAP_L, OFF_FLAGS, 8'h3C};
    logic [3:0] modes[4] = '{WM_CTC_A, WM_PC8, WM_PC10, WM_PFC_A};
    logic [15:0] starts[4] = '{16'h0000, 16'h00F0, 16'h03F0, 16'h0000};
    logic [15:0] tops[4] = '{16'h0005, TOP_8, TOP_10, 16'h0005};
    assign hready = hreadyout;
    tmc_timer tmc_timer_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(cap_pin),
        .external_count_pin(cnt_pin), .compare_out_a(out_a), .compare_out_b(out_b),
        .compare_out_a_en(en_a), .compare_out_b_en(en_b), .flags(flags));
    tmc_pin_model tmc_pin_model_i (.clk(clk), .capture_input_pin(cap_pin),
        .external_count_pin(cnt_pin));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Single word transfer; read data is taken at the closing edge of the data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // High byte first so the low byte commits both halves
    task automatic wr16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] d);
        xfer(1'b1, ah, {24'h0, d[15:8]});
        xfer(1'b1, al, {24'h0, d[7:0]});
    endtask
    task automatic rd16(input logic [7:0] al, input logic [7:0] ah);
        xfer(1'b0, al, RD_ZERO);
        v[7:0] = q[7:0];
        xfer(1'b0, ah, RD_ZERO);
        v[15:8] = q[7:0];
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_range(input logic [31:0] got, input logic [31:0] lo,
        input logic [31:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            errors++;
            $display("FAIL at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        report_and_stop();
    end
    initial
    begin
        {rst_n, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (offs[i])
        begin
            xfer(1'b0, offs[i], RD_ZERO);
            check_val(q, RD_ZERO);
        end
        xfer(1'b1, OFF_CTRL_B, 32'hD8);
        xfer(1'b0, OFF_CTRL_B, RD_ZERO);
        check_val(q, 32'hD8);
        xfer(1'b1, OFF_CTRL_B, RD_ZERO);
        xfer(1'b1, OFF_FORCE, 32'hC0);
        xfer(1'b0, OFF_FORCE, RD_ZERO);
        check_val(q, RD_ZERO);
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h1234);
        wr16(OFF_CMPA_H, OFF_CMPA_L, 16'hABCD);
        rd16(OFF_CNT_L, OFF_CNT_H);
        check_val({16'h0, v}, 32'h1234);
        rd16(OFF_CMPA_L, OFF_CMPA_H);
        check_val({16'h0, v}, 32'hABCD);
        $display("registers test done");
        for (int i = 0; i < 5; i++)
        begin
            wr16(OFF_CNT_H, OFF_CNT_L, 16'h0000);
            xfer(1'b1, OFF_CTRL_B, {29'h0, CS_D1 + 3'(i)});
            repeat (divs[i] * 8) @(posedge clk);
            xfer(1'b1, OFF_CTRL_B, RD_ZERO);
            rd16(OFF_CNT_L, OFF_CNT_H);
            check_range({16'h0, v}, 32'd7, 32'(9 + 4 / divs[i]));
        end
        for (int e = 0; e < 2; e++)
        begin
            wr16(OFF_CNT_H, OFF_CNT_L, 16'h0000);
            xfer(1'b1, OFF_CTRL_B, {29'h0, CS_EXT_FALL + 3'(e)});
            tmc_pin_model_i.count_pulses(5);
            xfer(1'b1, OFF_CTRL_B, RD_ZERO);
            rd16(OFF_CNT_L, OFF_CNT_H);
            check_val({16'h0, v}, 32'h5);
        end
        $display("clock source test done");
        xfer(1'b1, OFF_FLAGS, 32'h27);
        xfer(1'b1, OFF_CTRL_A, 32'h50);
        xfer(1'b1, OFF_FORCE, 32'hC0);
        repeat (3) @(posedge clk);
        check_val({27'h0, out_a, out_b, en_a, en_b, hresp}, 32'h1E);
        check_val({28'h0, flags}, 32'h0);
        wr16(OFF_CMPA_H, OFF_CMPA_L, 16'h0005);
        xfer(1'b1, OFF_CTRL_B, {29'h0, CS_D1});
        repeat (40) @(posedge clk);
        check_val({30'h0, flags[1], out_a}, 32'h2);
        xfer(1'b1, OFF_CTRL_B, RD_ZERO);
        wr16(OFF_CMPB_H, OFF_CMPB_L, 16'h0100);
        xfer(1'b1, OFF_FLAGS, 32'h27);
        xfer(1'b1, OFF_CTRL_B, {29'h0, CS_D1024});
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h0100);
        repeat (2100) @(posedge clk);
        check_val({31'h0, flags[2]}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, OFF_CTRL_B, RD_ZERO);
            wr16(OFF_CNT_H, OFF_CNT_L, starts[i]);
            xfer(1'b1, OFF_CTRL_A, {30'h0, modes[i][1:0]});
            xfer(1'b1, OFF_CTRL_B, {27'h0, modes[i][3:2], CS_D1});
            repeat (40) @(posedge clk);
            xfer(1'b1, OFF_CTRL_B, RD_ZERO);
            rd16(OFF_CNT_L, OFF_CNT_H);
            check_range({16'h0, v}, 32'h0, {16'h0, tops[i]});
        end
        $display("compare and mode test done");
        xfer(1'b1, OFF_CTRL_A, RD_ZERO);
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h0222);
        xfer(1'b1, OFF_FLAGS, 32'h27);
        xfer(1'b1, OFF_CTRL_B, 32'h40);
        tmc_pin_model_i.drive_capture(1'b1, 10);
        rd16(OFF_CAP_L, OFF_CAP_H);
        check_val({15'h0, flags[3], v}, 32'h1_0222);
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h0333);
        xfer(1'b1, OFF_CTRL_B, RD_ZERO);
        tmc_pin_model_i.drive_capture(1'b0, 10);
        rd16(OFF_CAP_L, OFF_CAP_H);
        check_val({16'h0, v}, 32'h0333);
        xfer(1'b1, OFF_CTRL_B, 32'hC0);
        xfer(1'b1, OFF_FLAGS, 32'h27);
        tmc_pin_model_i.drive_capture(1'b1, 2);
        tmc_pin_model_i.drive_capture(1'b0, 10);
        check_val({31'h0, flags[3]}, 32'h0);
        tmc_pin_model_i.drive_capture(1'b1, 10);
        check_val({31'h0, flags[3]}, 32'h1);
        xfer(1'b1, OFF_CTRL_B, 32'h58);
        xfer(1'b1, OFF_FLAGS, 32'h27);
        tmc_pin_model_i.drive_capture(1'b0, 10);
        tmc_pin_model_i.drive_capture(1'b1, 10);
        check_val({31'h0, flags[3]}, 32'h0);
        xfer(1'b1, OFF_CTRL_A, 32'h41);
        xfer(1'b1, OFF_CTRL_B, 32'h18);
        repeat (3) @(posedge clk);
        check_val({31'h0, en_a}, 32'h0);
        $display("capture and reserved mode test done");
        report_and_stop();
    end
endmodule
